// *** rtl/nor_flash_host.sv ***
// Purpose: host side controller driving a parallel nor flash through its pins
// Assumes: device pins are asynchronous; read data and ready/busy are synchronised
// Notes: one access at a time; width select is a static input latched per access
//
// Function
// - width select held steady, always driven
// - reset held low minimum pulse time
// - wait later reset delay before first access
// - polling reads ignore data bits fourteen to eight
// - low ready line means some device busy
// - output enable high through every write
`timescale 1ns/100ps
module nor_flash_host
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire nor_host_pkg::host_req_t req,
  input wire logic mode_x16,
  input wire logic poll_read,
  input wire logic flash_reset_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [nor_host_pkg::DATA_W-1:0] rsp_data,
  output logic dev_busy,
  output nor_host_pkg::ctrl_pins_t pins,
  output logic [nor_host_pkg::ADDR_W-1:0] addr_pin,
  output logic [nor_host_pkg::DATA_W-1:0] dq_out,
  output logic [nor_host_pkg::DATA_W-1:0] dq_oe,
  input wire logic [nor_host_pkg::DATA_W-1:0] dq_in,
  input wire logic ready_busy_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [nor_host_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;

  // pins come from an unclocked device, two stages before use
  always_ff @(posedge clk)
  begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
    rb_s1_r <= ready_busy_n;
    rb_s2_r <= rb_s1_r;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  nor_host_pkg::host_state_t st_r, st_nxt;
  logic [nor_host_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  nor_host_pkg::host_req_t cur_r, cur_nxt;
  logic x16_r, x16_nxt;
  logic poll_r, poll_nxt;
  nor_host_pkg::ctrl_pins_t pins_nxt;
  logic [nor_host_pkg::ADDR_W-1:0] addr_nxt;
  logic [nor_host_pkg::DATA_W-1:0] dqo_nxt, dqoe_nxt, rdata_nxt;
  logic rdy_nxt, rsp_nxt, busy_nxt;
  logic [nor_host_pkg::DATA_W-1:0] rd_raw;

  // next state and pin values; pins are registered so every output is a flop
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cur_nxt = cur_r;
    x16_nxt = x16_r;
    poll_nxt = poll_r;
    rsp_nxt = 1'b0;
    rdata_nxt = rsp_data;
    busy_nxt = ~rb_s2_r;
    rd_raw = dq_s2_r;
    pins_nxt.chip_sel_n = 1'b1;
    pins_nxt.out_en_n = 1'b1;
    pins_nxt.wr_strobe_n = 1'b1;
    pins_nxt.reset_n = 1'b1;
    pins_nxt.byte_mode_n = x16_r;
    addr_nxt = addr_pin;
    dqo_nxt = dq_out;
    dqoe_nxt = '0;
    rdy_nxt = 1'b0;
    case (st_r)
      nor_host_pkg::ST_RST:
      begin
        pins_nxt.reset_n = 1'b0;
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r >= 8'(nor_host_pkg::RESET_PULSE_CYC - 1))
        begin
          st_nxt = nor_host_pkg::ST_RWAIT;
          cnt_nxt = '0;
        end
      end
      nor_host_pkg::ST_RWAIT:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r >= 8'(nor_host_pkg::RESET_WAIT_CYC - 1))
        begin
          st_nxt = nor_host_pkg::ST_IDLE;
          rdy_nxt = 1'b1;
        end
      end
      nor_host_pkg::ST_IDLE:
      begin
        rdy_nxt = 1'b1;
        // width pin tracks the input while idle so it settles before select falls;
        // limitation: the width must be set one cycle ahead of its request
        x16_nxt = mode_x16;
        pins_nxt.byte_mode_n = mode_x16;
        if (flash_reset_req)
        begin
          st_nxt = nor_host_pkg::ST_RST;
          cnt_nxt = '0;
          rdy_nxt = 1'b0;
        end
        else if (req_valid && req_ready)
        begin
          rdy_nxt = 1'b0;
          cur_nxt = req;
          x16_nxt = mode_x16; // width only changes between accesses
          poll_nxt = poll_read;
          pins_nxt.byte_mode_n = mode_x16;
          pins_nxt.chip_sel_n = 1'b0;
          addr_nxt = req.addr;
          cnt_nxt = '0;
          if (req.write)
          begin
            st_nxt = nor_host_pkg::ST_WSTRB;
            // byte mode puts address lsb on the top pin
            dqo_nxt = mode_x16 ? req.wdata : {req.addr[0], 7'h00, req.wdata[7:0]};
            dqoe_nxt = mode_x16 ? 16'hFFFF : 16'h80FF;
            addr_nxt = mode_x16 ? req.addr : {1'b0, req.addr[nor_host_pkg::ADDR_W-1:1]};
          end
          else
          begin
            st_nxt = nor_host_pkg::ST_RSETUP;
            dqo_nxt = {req.addr[0], 15'h0000};
            dqoe_nxt = mode_x16 ? 16'h0000 : 16'h8000;
            addr_nxt = mode_x16 ? req.addr : {1'b0, req.addr[nor_host_pkg::ADDR_W-1:1]};
          end
        end
      end
      nor_host_pkg::ST_RSETUP:
      begin
        pins_nxt.chip_sel_n = 1'b0;
        pins_nxt.out_en_n = 1'b0;
        dqoe_nxt = dq_oe;
        st_nxt = nor_host_pkg::ST_RACC;
      end
      nor_host_pkg::ST_RACC:
      begin
        pins_nxt.chip_sel_n = 1'b0;
        pins_nxt.out_en_n = 1'b0;
        dqoe_nxt = dq_oe;
        cnt_nxt = cnt_r + 8'h01;
        // two extra cycles cover the synchroniser delay on read data
        if (cnt_r >= 8'(nor_host_pkg::ACCESS_CYC + 1))
        begin
          pins_nxt.chip_sel_n = 1'b1;
          pins_nxt.out_en_n = 1'b1;
          dqoe_nxt = '0;
          rsp_nxt = 1'b1;
          // upper byte masked in byte mode, bits 14 to 8 in status polling
          if (!x16_r)
            rdata_nxt = {8'h00, rd_raw[7:0]};
          else if (poll_r)
            rdata_nxt = {rd_raw[15], 7'h00, rd_raw[7:0]};
          else
            rdata_nxt = rd_raw;
          st_nxt = nor_host_pkg::ST_RECOV;
          cnt_nxt = '0;
        end
      end
      nor_host_pkg::ST_WSTRB:
      begin
        pins_nxt.chip_sel_n = 1'b0;
        dqoe_nxt = dq_oe;
        cnt_nxt = cnt_r + 8'h01;
        // strobe low only after setup, released before select and data
        if (cnt_r >= 8'(nor_host_pkg::SETUP_CYC) &&
            cnt_r < 8'(nor_host_pkg::SETUP_CYC + nor_host_pkg::STROBE_CYC))
          pins_nxt.wr_strobe_n = 1'b0;
        // select and data drop one cycle after the strobe rise, so both outlast it
        if (cnt_r >= 8'(nor_host_pkg::SETUP_CYC + nor_host_pkg::STROBE_CYC + 1))
        begin
          pins_nxt.chip_sel_n = 1'b1;
          dqoe_nxt = '0;
          rsp_nxt = 1'b1;
          st_nxt = nor_host_pkg::ST_RECOV;
          cnt_nxt = '0;
        end
      end
      nor_host_pkg::ST_RECOV:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r >= 8'(nor_host_pkg::RECOVER_CYC - 1))
        begin
          st_nxt = nor_host_pkg::ST_IDLE;
          rdy_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt = nor_host_pkg::ST_RST;
        cnt_nxt = '0;
      end
    endcase
  end

  // registers only; synchronous reset starts the flash reset pulse
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= nor_host_pkg::ST_RST;
      cnt_r <= '0;
      cur_r <= '0;
      x16_r <= 1'b1;
      poll_r <= 1'b0;
      pins <= 5'h1D;
      addr_pin <= '0;
      dq_out <= '0;
      dq_oe <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      dev_busy <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
      x16_r <= x16_nxt;
      poll_r <= poll_nxt;
      pins <= pins_nxt;
      addr_pin <= addr_nxt;
      dq_out <= dqo_nxt;
      dq_oe <= dqoe_nxt;
      req_ready <= rdy_nxt;
      rsp_valid <= rsp_nxt;
      rsp_data <= rdata_nxt;
      dev_busy <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_oe_needs_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.out_en_n |-> !pins.chip_sel_n) else $error("oe low without select");
  a_we_needs_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.wr_strobe_n |-> !pins.chip_sel_n) else $error("strobe low without select");
  a_oe_high_write: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.wr_strobe_n |-> pins.out_en_n) else $error("oe low during write");
  a_data_hold_rise: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins.wr_strobe_n) |-> (dq_oe != 16'h0000) && !pins.chip_sel_n)
    else $error("data dropped at strobe rise");
  a_reset_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins.reset_n) |-> !pins.reset_n [*8]) else $error("reset pulse too short");
  a_no_access_rst: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins.reset_n) |-> pins.chip_sel_n [*8]) else $error("access too soon after reset");
  a_byte_upper_z: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.byte_mode_n |-> dq_oe[14:8] == 7'h00) else $error("upper bits driven in byte mode");
  a_width_steady: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.chip_sel_n |-> $stable(pins.byte_mode_n)) else $error("width changed in access");
  a_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins.wr_strobe_n) |-> !pins.wr_strobe_n [*3]) else $error("strobe too short");
  a_busy_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !rb_s2_r |=> dev_busy) else $error("busy not reported");
  c_read: cover property (@(posedge clk) rsp_valid && !cur_r.write);
  c_write: cover property (@(posedge clk) rsp_valid && cur_r.write);
  c_byte_write: cover property (@(posedge clk) !pins.wr_strobe_n && !pins.byte_mode_n);
  c_busy: cover property (@(posedge clk) dev_busy);

endmodule : nor_flash_host

// *** rtl/nor_host_pkg.sv ***
// Purpose: shared constants and carrier types for the parallel nor flash host controller
// Assumes: 50 MHz system clock, device pins driven directly by the host
// Notes: timing figures are parameters of plain default; real parts set them
package nor_host_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 20;

  // ----------------------------------------------------------------
  // timing, in ns, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_TO_SELECT_DELAY_NS = 200;
  localparam int RESET_TO_STROBE_DELAY_NS = 200;
  localparam int ACCESS_NS = 80;
  localparam int STROBE_NS = 60;
  localparam int RECOVER_NS = 40;
  localparam int SETUP_NS = 20;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_WAIT_NS = (RESET_TO_SELECT_DELAY_NS > RESET_TO_STROBE_DELAY_NS) ?
                                 RESET_TO_SELECT_DELAY_NS : RESET_TO_STROBE_DELAY_NS;
  localparam int RESET_WAIT_CYC = (RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_strobe_n;
    logic reset_n;
    logic byte_mode_n;
  } ctrl_pins_t;

  typedef enum logic [6:0] {
    ST_RST    = 7'h01,
    ST_RWAIT  = 7'h02,
    ST_IDLE   = 7'h04,
    ST_RSETUP = 7'h08,
    ST_RACC   = 7'h10,
    ST_WSTRB  = 7'h20,
    ST_RECOV  = 7'h40
  } host_state_t;

endpackage : nor_host_pkg

// *** sim/nor_flash_model.sv ***
// Purpose: behavioural parallel nor flash on the host pins
// Assumes: no clock; pin edges and levels only
// Notes: every write programs; busy lasts BUSY_NS
`timescale 1ns/100ps
module nor_flash_model
#(
  parameter int BUSY_NS = 400
)
(
  input wire nor_host_pkg::ctrl_pins_t pins,
  input wire logic [23:0] addr_pin,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe,
  output logic [15:0] dq_line,
  output logic ready_busy_n
);
  // ----------------------------------------
  // array, pins and busy line
  // ----------------------------------------
  logic [7:0] mem [logic [24:0]];
  logic [24:0] wa;
  logic [15:0] flt = 16'h5A5A;
  logic busy = 1'b0;
  logic [15:0] rw;
  event prog_ev;
  wire x16 = pins.byte_mode_n;
  wire on = !pins.chip_sel_n && pins.reset_n;
  wire rd = on && !pins.out_en_n && pins.wr_strobe_n;
  wire [24:0] ba = x16 ? {addr_pin, 1'b0} : {addr_pin, dq_line[15]};
  wire [15:0] doe = !rd ? 16'h0000 : x16 ? 16'hFFFF : 16'h00FF;
  function automatic logic [7:0] byt(input logic [24:0] a);
    return mem.exists(a) ? mem[a] : ~a[7:0];
  endfunction : byt
  // floating lines keep moving so a stale value never passes
  always #10 flt = ~flt;
  // polled, since the floating value flt changes without any pin event
  always
  begin
    #1;
    rw = {byt(ba + 25'h1), byt(ba)};
    for (int i = 0; i < 16; i++)
      dq_line[i] = dq_oe[i] ? dq_out[i] : doe[i] ? rw[i] : flt[i];
  end
  // address at the later falling edge of select and strobe
  always @(negedge pins.wr_strobe_n or negedge pins.chip_sel_n)
    if (on && !pins.wr_strobe_n) wa = ba;
  // data at the first rising edge of select or strobe
  always @(posedge pins.wr_strobe_n or posedge pins.chip_sel_n)
  begin
    if (pins.reset_n && pins.chip_sel_n != pins.wr_strobe_n)
    begin
      mem[wa] = dq_line[7:0];
      if (x16) mem[wa + 25'h1] = dq_line[15:8];
      -> prog_ev;
    end
  end
  // program holds the line low; released it is driven high
  always @(prog_ev)
  begin
    busy = 1'b1;
    #(BUSY_NS) busy = 1'b0;
  end
  assign ready_busy_n = busy ? 1'b0 : 1'b1;
endmodule : nor_flash_model

// *** sim/tb.sv ***
// Purpose: self-checking bench for the nor flash host controller
// Assumes: flash model on the pins, 50 MHz clock
// Notes: read data expected from a shadow of every write
`timescale 1ns/100ps
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  nor_host_pkg::host_req_t req = '0;
  logic mode_x16 = 1'b1;
  logic poll_read = 1'b0;
  logic flash_reset_req = 1'b0;
  logic req_ready, rsp_valid, dev_busy, ready_busy_n;
  logic [15:0] rsp_data, dq_out, dq_oe, dq_line;
  logic [23:0] addr_pin;
  nor_host_pkg::ctrl_pins_t pins;
  logic [16:0] exp_q[$];
  logic [16:0] mon_e;
  logic [7:0] sh [logic [24:0]];
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'h3EF2;
  int n;
  logic [31:0] r;
  localparam int RST_CYC = nor_host_pkg::RESET_PULSE_CYC + nor_host_pkg::RESET_WAIT_CYC;
  always #10 clk = ~clk;
  nor_flash_host dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .mode_x16(mode_x16), .poll_read(poll_read), .flash_reset_req(flash_reset_req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_busy(dev_busy),
    .pins(pins), .addr_pin(addr_pin), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_line),
    .ready_busy_n(ready_busy_n));
  nor_flash_model #(.BUSY_NS(400)) flash_u (.pins(pins), .addr_pin(addr_pin),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_line(dq_line), .ready_busy_n(ready_busy_n));
  function automatic logic [7:0] sb(input logic [24:0] a);
    return sh.exists(a) ? sh[a] : ~a[7:0];
  endfunction : sb
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (req_ready !== 1'b1 && cnt < 200)
    begin
      @(negedge clk);
      cnt++;
    end
    chk("req_ready", 1, req_ready);
  endtask : wait_ready
  // width is only changed while idle and a cycle ahead, so it stays steady through a write
  task automatic access(input logic wr, input logic x16, input logic poll,
                        input logic [23:0] a, input logic [15:0] d);
    logic [24:0] b;
    logic [15:0] e;
    wait_ready(n);
    b = x16 ? {a, 1'b0} : {1'b0, a};
    e = x16 ? {sb(b + 25'h1), sb(b)} : {8'h00, sb(b)};
    if (x16 && poll) e[14:8] = 7'h00;
    if (wr) sh[b] = d[7:0];
    if (wr && x16) sh[b + 25'h1] = d[15:8];
    exp_q.push_back({!wr, e});
    mode_x16 = x16;
    poll_read = poll;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{wr, a, d};
    @(negedge clk);
    req_valid = 1'b0;
  endtask : access
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    chk("pins_in_reset", 5'h1D, pins);
    sys_rst = 1'b0;
    repeat (nor_host_pkg::RESET_PULSE_CYC - 1) @(negedge clk);
    chk("flash_reset_n", 0, pins.reset_n);
    wait_ready(n);
    chk("reset_to_ready", 1, n + nor_host_pkg::RESET_PULSE_CYC - 1 >= RST_CYC);
  endtask : do_reset
  // watcher: pin relations each cycle, responses against the oldest note
  always @(negedge clk)
  begin
    if (pins.wr_strobe_n === 1'b0) chk("oe_in_write", 1, pins.out_en_n);
    if (pins.out_en_n === 1'b0) chk("we_in_read", 1, pins.wr_strobe_n);
    if (pins.chip_sel_n === 1'b0) chk("width_pin", mode_x16, pins.byte_mode_n);
    if (!sys_rst && rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0) chk("rsp_extra", 0, 1);
      else
      begin
        mon_e = exp_q.pop_front();
        if (mon_e[16]) chk("rsp_data", mon_e[15:0], rsp_data);
      end
    end
  end
  // main sequence
  initial
  begin
    do_reset();
    access(1'b1, 1'b1, 1'b0, 24'h000010, 16'h1234);
    repeat (10) @(negedge clk);
    chk("busy_high", 1, dev_busy);
    repeat (25) @(negedge clk);
    chk("busy_low", 0, dev_busy);
    repeat (48)
    begin
      r = $random(seed);
      access(r[0], r[1], r[2], {20'h00000, r[7:4]}, r[23:8]);
    end
    wait_ready(n);
    flash_reset_req = 1'b1;
    @(negedge clk);
    flash_reset_req = 1'b0;
    repeat (3) @(negedge clk);
    chk("flash_reset_req", 0, pins.reset_n);
    access(1'b0, 1'b1, 1'b0, 24'h000010, 16'h0000);
    wait_ready(n);
    do_reset();
    access(1'b0, 1'b0, 1'b0, 24'h000021, 16'h0000);
    wait_ready(n);
    chk("rsp_all", 0, exp_q.size());
    finish_test();
  end
  // cut a hang short
  initial
  begin
    #300000;
    mismatches++;
    finish_test();
  end
endmodule : tb
